// ---- src/pisw_defs.vh ----
// register offsets, field positions, reset values and timing counts for the
// peripheral interrupt / sleep-wake block; included by the design file only
`ifndef PISW_DEFS_VH
`define PISW_DEFS_VH

// register byte offsets on the AXI4-Lite slave
`define PISW_OFF_INTERRUPT_CONTROL 5'h00
`define PISW_OFF_PERIPH_IRQ_ENABLE_1 5'h04
`define PISW_OFF_PERIPH_IRQ_ENABLE_2 5'h08
`define PISW_OFF_PERIPH_IRQ_FLAGS_1 5'h0c
`define PISW_OFF_PERIPH_IRQ_FLAGS_2 5'h18
`define PISW_OFF_STATUS 5'h10
`define PISW_OFF_WDT_CONTROL 5'h14

// interrupt_control fields
`define PISW_BIT_GLOBAL_IRQ_ENABLE 7
`define PISW_BIT_PERIPHERAL_IRQ_GATE 6
// enable / flag fields
`define PISW_BIT_ADC 6
`define PISW_BIT_SERIAL_PORT 3
`define PISW_BIT_BUS_COLLISION 3
// status fields
`define PISW_BIT_WATCHDOG_EXPIRY 4
`define PISW_BIT_SLEEP_ENTERED 3
`define PISW_BIT_ASLEEP 0
// wdt control fields
`define PISW_BIT_WDT_ENABLE 0
`define PISW_BIT_WDT_SLEEP_RUN 1

// writable masks and reset values
`define PISW_MASK_INTERRUPT_CONTROL 8'hc0
`define PISW_MASK_EN1 8'h48
`define PISW_MASK_EN2 8'h08
`define PISW_MASK_FLAGS1 8'h48
`define PISW_MASK_FLAGS2 8'h08
`define PISW_MASK_WDT_CTRL 8'h03
`define PISW_RESET_REG 8'h00
`define PISW_RESET_WDT_CTRL 8'h00

// low-frequency tick: 31 kHz from 100 MHz, 3225 cycles (integer division)
`define PISW_LF_OSC_KHZ 31
`define PISW_CLK_KHZ 100000
`define PISW_LF_DIV (`PISW_CLK_KHZ / `PISW_LF_OSC_KHZ)
`define PISW_WDT_PERIOD_TICKS 2048

`endif

// ---- src/pisw_periph_irq_sleep_wake.v ----
// peripheral interrupt enables and flags, gating to the core, and the
// sleep / wake sequencer with watchdog clearing and status flags.
// assumes: one 100 MHz clock, AXI4-Lite master, core gives a one-cycle
// sleep_instr pulse and holds off the next fetch while cpu_clk_en is low.
// pin, brown-out and power-on resets arrive already merged into aresetn;
// event inputs come from logic on aclk and need no synchroniser.
//
// What this block does
// - enable 1 register bit 6 enables the ADC interrupt.
// - enable 1 register bit 3 enables the serial port interrupt.
// - enable 2 register bit 3 enables the bus collision interrupt.
// - flags 1 register bit 6 shows ADC interrupt pending.
// - flags 1 register bit 3 shows serial port interrupt pending.
// - flags 2 register bit 3 shows bus collision pending.
// - unused bits read zero; control, enable and flag bits read/write, reset to zero.
// - peripheral interrupts need the peripheral gate bit set too.
// - flags set on their event regardless of any enable.
// - only the sleep instruction enters power-down.
// - sleep entry clears watchdog; it counts on only if sleep-enabled.
// - sleep entry clears sleep flag, sets expiry flag, stops cpu clock.
// - low-frequency tick and peripherals keep running during sleep.
// - non-watchdog resets work unchanged while asleep.
// - resets wake by reset; watchdog, external, peripheral irq resume.
// - a source wakes only when individually enabled, whatever global enable.
// - the next instruction is prefetched while sleep executes.
// - after wake run next instruction, then vector if global enable set.
// - watchdog cleared whenever sleep is left.
// - pending enabled irq before sleep makes sleep a no-op.
// - irq during sleep: sleep completes, wakes at once, flags updated.
// - control bit 7 is the global interrupt enable.
`timescale 1ns/1ns
`default_nettype none
`include "pisw_defs.vh"

module pisw_periph_irq_sleep_wake #(
    parameter LF_DIV = `PISW_LF_DIV,
    parameter WDT_TICKS = `PISW_WDT_PERIOD_TICKS
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // peripheral events, one-cycle pulses from on-chip logic
    input wire adc_done,
    input wire serial_port_event,
    input wire bus_collision_event,
    // other wake sources (external edge, timer etc.) already enabled
    input wire ext_wake_req,
    // core handshake
    input wire sleep_instr,
    input wire clrwdt_instr,
    output reg cpu_clk_en,
    output reg prefetch_next,
    output reg periph_irq_req,
    output reg vector_req,
    output reg asleep,
    output reg wdt_reset
);

    // ======================================================================
    // state encoding
    localparam [2:0] ST_RUN = 3'b001;
    localparam [2:0] ST_SLEEP = 3'b010;
    localparam [2:0] ST_RESUME = 3'b100;

    // ======================================================================
    // registers
    reg [7:0] interrupt_control_reg;
    reg [7:0] en1_reg;
    reg [7:0] en2_reg;
    reg [7:0] flags1_reg;
    reg [7:0] flags2_reg;
    reg [7:0] wdt_ctrl_reg;
    reg sleep_entered_flag_reg;
    reg watchdog_expiry_flag_reg;
    reg [2:0] state_reg;
    reg [11:0] lf_cnt_reg;
    reg lf_tick_reg;
    reg [23:0] wdt_cnt_reg;
    reg [31:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg aw_held_reg;
    reg w_held_reg;

    wire [7:0] ev1;
    wire [7:0] ev2;
    wire pending_enabled;
    wire wdt_run;
    wire wdt_clear;
    wire wdt_expired;
    wire do_write;
    wire [7:0] wbyte;
    wire [4:0] wsel;
    wire addr_in_block;
    wire reg_wr;
    wire flags1_wr;
    wire flags2_wr;
    wire sleep_go;
    wire wake_event;
    wire wdt_fire;

    // ======================================================================
    // event placement and gating
    assign ev1 = {1'b0, adc_done, 2'b00, serial_port_event, 3'b000};
    assign ev2 = {4'b0000, bus_collision_event, 3'b000};
    // wake uses individual enables only, not the global enable
    assign pending_enabled = (|(flags1_reg & en1_reg))
        | (|(flags2_reg & en2_reg));

    assign wdt_run = wdt_ctrl_reg[`PISW_BIT_WDT_ENABLE] &
        ((state_reg != ST_SLEEP) | wdt_ctrl_reg[`PISW_BIT_WDT_SLEEP_RUN]);
    assign wdt_expired = (wdt_cnt_reg >= WDT_TICKS[23:0]);

    // ======================================================================
    // axi4-lite write path: address and data accepted in either order
    assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign wbyte = wdata_reg[7:0];
    assign wsel = awaddr_reg[4:0];
    // upper address bits must be zero for any register to respond
    assign addr_in_block = (awaddr_reg[31:5] == 27'h0);
    // registers are one byte wide: a write without lane 0 changes nothing,
    // rather than clearing the register as a zero byte would
    assign reg_wr = do_write & addr_in_block & wstrb_reg[0];
    assign flags1_wr = reg_wr & (wsel == `PISW_OFF_PERIPH_IRQ_FLAGS_1);
    assign flags2_wr = reg_wr & (wsel == `PISW_OFF_PERIPH_IRQ_FLAGS_2);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 32'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // unmapped word answers slverr
                s_axi_bresp <= (addr_in_block && wsel[1:0] == 2'b00 &&
                    wsel <= `PISW_OFF_PERIPH_IRQ_FLAGS_2)
                    ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ======================================================================
    // control and flag registers
    always @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_control_reg <= `PISW_RESET_REG;
            en1_reg <= `PISW_RESET_REG;
            en2_reg <= `PISW_RESET_REG;
            flags1_reg <= `PISW_RESET_REG;
            flags2_reg <= `PISW_RESET_REG;
            wdt_ctrl_reg <= `PISW_RESET_WDT_CTRL;
        end else begin
            if (reg_wr) begin
                case (wsel)
                    `PISW_OFF_INTERRUPT_CONTROL: begin
                        interrupt_control_reg <= wbyte & `PISW_MASK_INTERRUPT_CONTROL;
                    end
                    `PISW_OFF_PERIPH_IRQ_ENABLE_1: begin
                        en1_reg <= wbyte & `PISW_MASK_EN1;
                    end
                    `PISW_OFF_PERIPH_IRQ_ENABLE_2: begin
                        en2_reg <= wbyte & `PISW_MASK_EN2;
                    end
                    `PISW_OFF_WDT_CONTROL: begin
                        wdt_ctrl_reg <= wbyte & `PISW_MASK_WDT_CTRL;
                    end
                    default: ;
                endcase
            end
            // flags: a hardware set wins over a clearing write in the same
            // cycle, so an event is never lost to software
            if (flags1_wr) begin
                flags1_reg <= (wbyte & `PISW_MASK_FLAGS1) | ev1;
            end else begin
                flags1_reg <= flags1_reg | ev1;
            end
            if (flags2_wr) begin
                flags2_reg <= (wbyte & `PISW_MASK_FLAGS2) | ev2;
            end else begin
                flags2_reg <= flags2_reg | ev2;
            end
        end
    end

    // ======================================================================
    // axi4-lite read path
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                s_axi_rdata <= 32'h0;
                if (s_axi_araddr[31:5] != 27'h0) begin
                    s_axi_rresp <= 2'b10;
                end else begin
                    case (s_axi_araddr[4:0])
                        `PISW_OFF_INTERRUPT_CONTROL:
                            s_axi_rdata <= {24'h0, interrupt_control_reg};
                        `PISW_OFF_PERIPH_IRQ_ENABLE_1:
                            s_axi_rdata <= {24'h0, en1_reg};
                        `PISW_OFF_PERIPH_IRQ_ENABLE_2:
                            s_axi_rdata <= {24'h0, en2_reg};
                        `PISW_OFF_PERIPH_IRQ_FLAGS_1:
                            s_axi_rdata <= {24'h0, flags1_reg};
                        `PISW_OFF_PERIPH_IRQ_FLAGS_2:
                            s_axi_rdata <= {24'h0, flags2_reg};
                        `PISW_OFF_STATUS:
                            s_axi_rdata <= {27'h0,
                                watchdog_expiry_flag_reg,
                                sleep_entered_flag_reg, 2'b00,
                                state_reg == ST_SLEEP};
                        `PISW_OFF_WDT_CONTROL:
                            s_axi_rdata <= {24'h0, wdt_ctrl_reg};
                        default: s_axi_rresp <= 2'b10;
                    endcase
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ======================================================================
    // low-frequency tick keeps running in every state
    always @(posedge aclk) begin
        if (!aresetn) begin
            lf_cnt_reg <= 12'h000;
            lf_tick_reg <= 1'b0;
        end else if (lf_cnt_reg == LF_DIV[11:0] - 12'h001) begin
            lf_cnt_reg <= 12'h000;
            lf_tick_reg <= 1'b1;
        end else begin
            lf_cnt_reg <= lf_cnt_reg + 12'h001;
            lf_tick_reg <= 1'b0;
        end
    end

    // ======================================================================
    // sleep entry, wake and watchdog decisions
    // a sleep with an enabled flag already pending is a no-op
    // a watchdog reset request outranks a sleep in the same cycle, so the
    // core never sees a reset request while the block reports asleep
    assign wdt_fire = (state_reg == ST_RUN) & wdt_run & wdt_expired;
    assign sleep_go = (state_reg == ST_RUN) & sleep_instr
        & ~pending_enabled & ~wdt_fire;
    // in sleep the count only grows when it is allowed to run there
    assign wake_event = (state_reg == ST_SLEEP)
        & (pending_enabled | ext_wake_req | wdt_expired);
    // the count restarts after its own expiry and while disabled, so the
    // reset request stays a one-cycle pulse
    assign wdt_clear = clrwdt_instr | wdt_fire
        | ~wdt_ctrl_reg[`PISW_BIT_WDT_ENABLE]
        | sleep_go
        | wake_event;

    // ======================================================================
    // sleep / wake sequencer and watchdog

    always @(posedge aclk) begin
        // external pin, brown-out and power-on reach here as aresetn
        if (!aresetn) begin
            state_reg <= ST_RUN;
            sleep_entered_flag_reg <= 1'b1;
            watchdog_expiry_flag_reg <= 1'b1;
            wdt_cnt_reg <= 24'h0;
            cpu_clk_en <= 1'b1;
            prefetch_next <= 1'b0;
            vector_req <= 1'b0;
            asleep <= 1'b0;
            wdt_reset <= 1'b0;
            periph_irq_req <= 1'b0;
        end else begin
            prefetch_next <= 1'b0;
            vector_req <= 1'b0;
            wdt_reset <= 1'b0;
            periph_irq_req <= interrupt_control_reg[`PISW_BIT_GLOBAL_IRQ_ENABLE] &
                interrupt_control_reg[`PISW_BIT_PERIPHERAL_IRQ_GATE] &
                pending_enabled;
            if (wdt_clear) begin
                wdt_cnt_reg <= 24'h0;
            end else if (wdt_run && lf_tick_reg) begin
                wdt_cnt_reg <= wdt_cnt_reg + 24'h1;
            end
            case (state_reg)
                ST_RUN: begin
                    if (wdt_fire) begin
                        wdt_reset <= 1'b1;
                        watchdog_expiry_flag_reg <= 1'b0;
                    end
                    if (sleep_go) begin
                        state_reg <= ST_SLEEP;
                        sleep_entered_flag_reg <= 1'b0;
                        watchdog_expiry_flag_reg <= 1'b1;
                        cpu_clk_en <= 1'b0;
                        asleep <= 1'b1;
                        prefetch_next <= 1'b1;
                    end
                end
                ST_SLEEP: begin
                    // interrupt or watchdog resumes execution
                    if (wake_event) begin
                        state_reg <= ST_RESUME;
                        cpu_clk_en <= 1'b1;
                        asleep <= 1'b0;
                        if (wdt_expired && !pending_enabled && !ext_wake_req)
                            watchdog_expiry_flag_reg <= 1'b0;
                    end
                end
                ST_RESUME: begin
                    // one instruction runs before any vector
                    state_reg <= ST_RUN;
                    vector_req <= interrupt_control_reg[`PISW_BIT_GLOBAL_IRQ_ENABLE];
                end
                default: state_reg <= ST_RUN;
            endcase
        end
    end

endmodule // pisw_periph_irq_sleep_wake
`default_nettype wire

// ---- tb/pisw_props.sv ----
// checker for the peripheral irq / sleep-wake block
// assumes: bound to the top module; sees only its core-side ports
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// sleep / wake checker
module pisw_props (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // core side
    input wire logic sleep_instr,
    input wire logic ext_wake_req,
    input wire logic cpu_clk_en,
    input wire logic prefetch_next,
    input wire logic periph_irq_req,
    input wire logic vector_req,
    input wire logic asleep,
    input wire logic wdt_reset
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_entry;
        asleep && !cpu_clk_en && prefetch_next;
    endsequence
    sequence s_resumed;
        !asleep && cpu_clk_en;
    endsequence
    property p_sleep_cause;
        $rose(asleep) |-> $past(sleep_instr);
    endproperty
    a_sleep_cause: assert property (p_sleep_cause)
        else $error("asleep rose without a sleep instruction");
    property p_entry;
        $rose(asleep) |-> s_entry;
    endproperty
    a_entry: assert property (p_entry)
        else $error("sleep entry incomplete");
    property p_clk_stop;
        asleep |-> !cpu_clk_en;
    endproperty
    a_clk_stop: assert property (p_clk_stop)
        else $error("cpu clock running while asleep");
    property p_prefetch_pulse;
        prefetch_next |=> !prefetch_next;
    endproperty
    a_prefetch_pulse: assert property (p_prefetch_pulse)
        else $error("prefetch longer than one cycle");
    property p_ext_wake;
        asleep && ext_wake_req |=> s_resumed;
    endproperty
    a_ext_wake: assert property (p_ext_wake)
        else $error("no resume after external wake");
    property p_vector;
        vector_req |-> $past(asleep, 2) && !$past(asleep);
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector not one cycle after resume");
    property p_wdt_quiet;
        asleep |-> !wdt_reset;
    endproperty
    a_wdt_quiet: assert property (p_wdt_quiet)
        else $error("watchdog reset while asleep");
    property p_nop_sleep;
        sleep_instr && periph_irq_req && !asleep |=> !asleep;
    endproperty
    a_nop_sleep: assert property (p_nop_sleep)
        else $error("sleep entered with enabled irq pending");
endmodule // pisw_props

bind pisw_periph_irq_sleep_wake pisw_props u_props (.aclk, .aresetn,
    .sleep_instr, .ext_wake_req, .cpu_clk_en, .prefetch_next,
    .periph_irq_req, .vector_req, .asleep, .wdt_reset);
`default_nettype wire

// ---- tb/pisw_core_model.sv ----
// behavioural core: issues sleep and counts vectoring to the service routine
// assumes: requests come from the bench as one-cycle levels
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// core model
module pisw_core_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bench request
    input wire logic do_sleep,
    // block side
    input wire logic cpu_clk_en,
    input wire logic vector_req,
    output logic sleep_instr,
    output logic clrwdt_instr,
    output int vec_count
);
    // a stopped core cannot execute, so a sleep request is dropped while its clock is off
    // the word after sleep is modelled as a no-op: a wake adds no work
    always @(posedge aclk) begin
        sleep_instr <= aresetn && do_sleep && cpu_clk_en;
        clrwdt_instr <= 1'b0;
        if (!aresetn) begin
            vec_count <= 0;
        end else if (vector_req) begin
            vec_count <= vec_count + 1;
        end
    end
endmodule // pisw_core_model
`default_nettype wire

// ---- tb/pisw_periph_irq_sleep_wake_tb_top.sv ----
// self-checking bench for the peripheral irq / sleep-wake block
// assumes: AXI4-Lite slave registers, shortened watchdog counts
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("Error at %0t: got %h expected %h", $time, g, e); \
        end \
    end
// ==========================================
// bench top
module pisw_periph_irq_sleep_wake_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic adc_done = 1'b0, serial_port_event = 1'b0;
    logic bus_collision_event = 1'b0, ext_wake_req = 1'b0, do_sleep = 1'b0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic s_axi_rvalid, sleep_instr, clrwdt_instr, cpu_clk_en;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic prefetch_next, periph_irq_req, vector_req, asleep, wdt_reset;
    int errors = 0, check_count = 0, cyc = 0, vec_count;
    localparam logic [7:0] OFFS [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18,
        8'h10, 8'h14};
    localparam logic [7:0] RST [7] = '{0, 0, 0, 0, 0, 8'h18, 0};
    localparam logic [7:0] ONES [6] = '{8'hc0, 8'h48, 8'h08, 8'h48, 8'h08,
        8'h18};

    pisw_periph_irq_sleep_wake #(.LF_DIV(4), .WDT_TICKS(4)) u_dut (.*);
    pisw_core_model u_core (.aclk, .aresetn, .do_sleep, .cpu_clk_en,
        .vector_req, .sleep_instr, .clrwdt_instr, .vec_count);

    always #5 aclk = ~aclk;

    task automatic stop_test;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // sized for roughly fifty times the expected run
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            stop_test;
        end
    end

    task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, d);
        logic [1:0] r;
        axi_wr({24'h0, a}, {24'h0, d}, r);
    endtask

    task automatic rdc(input logic [7:0] a, e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd({24'h0, a}, d, r);
        `CHK(d, {24'h0, e})
        `CHK(r, 2'b00)
    endtask

    task automatic wreq(input logic [7:0] a, d, input logic e);
        wr(a, d);
        repeat (3) @(posedge aclk);
        `CHK(periph_irq_req, e)
    endtask

    task automatic pulse(input logic [2:0] m);
        @(posedge aclk);
        {adc_done, serial_port_event, bus_collision_event} <= m;
        @(posedge aclk);
        {adc_done, serial_port_event, bus_collision_event} <= 3'b0;
        repeat (4) @(posedge aclk);
    endtask

    task automatic go_sleep;
        @(posedge aclk);
        do_sleep <= 1'b1;
        @(posedge aclk);
        do_sleep <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 7; i++) rdc(OFFS[i], RST[i]);
        for (int i = 0; i < 6; i++) wr(OFFS[i], 8'hff);
        for (int i = 0; i < 6; i++) rdc(OFFS[i], ONES[i]);
        for (int i = 0; i < 6; i++) wr(OFFS[i], 8'h00);
        axi_wr(32'h1c, 32'hff, r);
        `CHK(r, 2'b10)
        axi_rd(32'h1c, d, r);
        `CHK(r, 2'b10)
        $display("t_regs done");
    endtask

    task automatic t_irq;
        pulse(3'b111);
        rdc(8'h0c, 8'h48);
        rdc(8'h18, 8'h08);
        wreq(8'h04, 8'h40, 1'b0);
        wreq(8'h00, 8'h80, 1'b0);
        wreq(8'h00, 8'hc0, 1'b1);
        go_sleep;
        `CHK(asleep, 1'b0)
        wreq(8'h0c, 8'h08, 1'b0);
        wreq(8'h04, 8'h08, 1'b1);
        wreq(8'h04, 8'h00, 1'b0);
        wreq(8'h08, 8'h08, 1'b1);
        wreq(8'h00, 8'h40, 1'b0);
        for (int i = 0; i < 5; i++) wr(OFFS[4 - i], 8'h00);
        $display("t_irq done");
    endtask

    task automatic t_sleep;
        int v;
        wr(8'h0c, 8'h00);
        wr(8'h04, 8'h40);
        go_sleep;
        `CHK(cpu_clk_en, 1'b0)
        rdc(8'h10, 8'h11);
        pulse(3'b010);
        `CHK(asleep, 1'b1)
        v = vec_count;
        pulse(3'b100);
        `CHK(asleep, 1'b0)
        `CHK(vec_count, v)
        rdc(8'h10, 8'h10);
        go_sleep;
        rdc(8'h10, 8'h10);
        wr(8'h0c, 8'h00);
        wr(8'h04, 8'h00);
        $display("t_sleep done");
    endtask

    task automatic t_vec;
        int v;
        wr(8'h00, 8'h80);
        go_sleep;
        `CHK(asleep, 1'b1)
        v = vec_count;
        @(posedge aclk);
        ext_wake_req <= 1'b1;
        @(posedge aclk);
        ext_wake_req <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK(asleep, 1'b0)
        `CHK(vec_count, v + 1)
        wr(8'h00, 8'h00);
        $display("t_vec done");
    endtask

    task automatic t_wdt;
        int n = 0;
        wr(8'h14, 8'h03);
        go_sleep;
        `CHK(asleep, 1'b1)
        while (asleep !== 1'b0 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        `CHK(asleep, 1'b0)
        rdc(8'h10, 8'h00);
        n = 0;
        while (wdt_reset !== 1'b1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        `CHK(wdt_reset, 1'b1)
        wr(8'h14, 8'h00);
        $display("t_wdt done");
    endtask

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_irq;
        t_sleep;
        t_vec;
        t_wdt;
        stop_test;
    end
endmodule // pisw_periph_irq_sleep_wake_tb_top
`default_nettype wire
